// file: bfx_pkg.sv
// package: opcodes, status flag positions, cycle counts for the bit and flag executor
package bfx_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W   = 16;
    localparam int K_W    = 7;

    // status flag bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    localparam logic [7:0] STATUS_RESET = 8'h00;

    // cycle counts
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;

    typedef enum logic [4:0] {
        OP_NOP                    = 5'h00,
        OP_BRANCH_ON_IRQ_ENABLED  = 5'h01,
        OP_BRANCH_ON_IRQ_DISABLED = 5'h02,
        OP_IO_BIT_SET             = 5'h03,
        OP_IO_BIT_CLEAR           = 5'h04,
        OP_SHIFT_LEFT_LOGICAL     = 5'h05,
        OP_SHIFT_RIGHT_LOGICAL    = 5'h06,
        OP_ROTATE_LEFT_CARRY      = 5'h07,
        OP_ROTATE_RIGHT_CARRY     = 5'h08,
        OP_ARITH_SHIFT_RIGHT      = 5'h09,
        OP_NIBBLE_SWAP            = 5'h0A,
        OP_GENERIC_FLAG_SET       = 5'h0B,
        OP_GENERIC_FLAG_CLEAR     = 5'h0C,
        OP_REG_BIT_TO_TRANSFER    = 5'h0D,
        OP_TRANSFER_TO_REG_BIT    = 5'h0E,
        OP_REGISTER_COPY          = 5'h0F,
        OP_REGISTER_PAIR_COPY     = 5'h10,
        OP_IMMEDIATE_LOAD         = 5'h11
    } bfx_op_type;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SECOND = 2'b01
    } bfx_state_type;
endpackage : bfx_pkg

// file: bfx_alu_if.sv
// interface: operand and result bundle between executor and shift unit
interface bfx_alu_if;
    logic [7:0]      operand;
    logic            carry_in;
    bfx_pkg::bfx_op_type op;
    logic [7:0]      result;
    logic [3:0]      flags;   // {v, n, z, c}
    modport exec  (output operand, output carry_in, output op, input result, input flags);
    modport shift (input operand, input carry_in, input op, output result, output flags);
endinterface : bfx_alu_if

// file: bfx_shift_unit.sv
// shift and rotate unit with flag generation
module bfx_shift_unit (
    bfx_alu_if.shift alu
);
    logic [7:0] res;
    logic       cout;
    logic       n;

    always_comb begin
        res  = alu.operand;
        cout = alu.carry_in;
        case (alu.op)
            bfx_pkg::OP_SHIFT_LEFT_LOGICAL: begin
                res  = {alu.operand[6:0], 1'b0};
                cout = alu.operand[7];
            end
            bfx_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
                res  = {1'b0, alu.operand[7:1]};
                cout = alu.operand[0];
            end
            bfx_pkg::OP_ROTATE_LEFT_CARRY: begin
                res  = {alu.operand[6:0], alu.carry_in};
                cout = alu.operand[7];
            end
            bfx_pkg::OP_ROTATE_RIGHT_CARRY: begin
                res  = {alu.carry_in, alu.operand[7:1]};
                cout = alu.operand[0];
            end
            bfx_pkg::OP_ARITH_SHIFT_RIGHT: begin
                res  = {alu.operand[7], alu.operand[7:1]};
                cout = alu.operand[0];
            end
            default: begin
                res  = alu.operand;
                cout = alu.carry_in;
            end
        endcase
        n = res[7];
    end

    // overflow follows n xor c for every shift form
    assign alu.result = res;
    assign alu.flags  = {n ^ cout, n, (res == 8'h00), cout};
endmodule : bfx_shift_unit

// file: bfx_exec.sv
// top: executes branch-on-interrupt, bit, shift, flag and move instructions
module bfx_exec #(
    parameter int PC_W = bfx_pkg::PC_W,
    parameter int K_W  = bfx_pkg::K_W
) (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    // instruction issue
    input  wire logic                 instr_valid,
    input  wire bfx_pkg::bfx_op_type  instr_op,
    input  wire logic [2:0]           instr_bit,
    input  wire logic [K_W-1:0]       instr_k,
    input  wire logic [7:0]           instr_imm,
    input  wire logic                 flag_op_set,
    input  wire logic [2:0]           flag_op_sel,
    // operands from register file and io space
    input  wire logic [7:0]           src_data,
    input  wire logic [7:0]           src_data_hi,
    input  wire logic [7:0]           dst_data,
    input  wire logic [7:0]           io_rd_data,
    input  wire logic [5:0]           io_addr_in,
    input  wire logic [PC_W-1:0]      pc_in,
    // results
    output logic                      busy,
    output logic                      done,
    output logic                      pc_load,
    output logic [PC_W-1:0]           pc_out,
    output logic                      rd_we,
    output logic                      rd_pair_we,
    output logic [7:0]                rd_data,
    output logic [7:0]                rd_data_hi,
    output logic                      io_we,
    output logic [5:0]                io_addr,
    output logic [7:0]                io_wr_data,
    output logic [7:0]                status_flags
);
    typedef struct packed {
        bfx_pkg::bfx_state_type state;
        logic                   busy;
        logic                   done;
        logic                   pc_load;
        logic [PC_W-1:0]        pc;
        logic                   rd_we;
        logic                   rd_pair_we;
        logic [7:0]             rd_data;
        logic [7:0]             rd_data_hi;
        logic                   io_we;
        logic [5:0]             io_addr;
        logic [7:0]             io_data;
        logic [7:0]             status_flags_register;
        bfx_pkg::bfx_op_type    op;       // op held for the second cycle
    } bfx_state_reg_type;

    bfx_state_reg_type st_q;
    bfx_state_reg_type st_d;

    // reset image spelled per field so the status reset value stays explicit
    localparam bfx_state_reg_type ST_RESET = '{
        state:      bfx_pkg::ST_IDLE,
        busy:       1'b0,
        done:       1'b0,
        pc_load:    1'b0,
        pc:         {PC_W{1'b0}},
        rd_we:      1'b0,
        rd_pair_we: 1'b0,
        rd_data:    8'h00,
        rd_data_hi: 8'h00,
        io_we:      1'b0,
        io_addr:    6'h00,
        io_data:    8'h00,
        status_flags_register:       bfx_pkg::STATUS_RESET,
        op:         bfx_pkg::OP_NOP
    };

    bfx_alu_if alu ();

    bfx_shift_unit u_shift (
        .alu (alu)
    );

    // sign-extended branch target, wraps in the counter width
    function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc,
                                                      input logic [K_W-1:0]  k);
        logic [PC_W-1:0] ext;
        ext = {{(PC_W-K_W){k[K_W-1]}}, k};
        return PC_W'(pc + ext + PC_W'(1));
    endfunction : branch_target

    function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] b,
                                           input logic val);
        logic [7:0] r;
        r    = v;
        r[b] = val;
        return r;
    endfunction : set_bit

    // branch forms share the second-cycle path with the io bit forms
    function automatic logic is_branch_op(input bfx_pkg::bfx_op_type op);
        return (op == bfx_pkg::OP_BRANCH_ON_IRQ_ENABLED) ||
               (op == bfx_pkg::OP_BRANCH_ON_IRQ_DISABLED);
    endfunction : is_branch_op

    // park in the second cycle; the issue port may move on, so the op is kept here
    function automatic bfx_state_reg_type enter_second(input bfx_state_reg_type   s,
                                                        input bfx_pkg::bfx_op_type op);
        bfx_state_reg_type r;
        r       = s;
        r.state = bfx_pkg::ST_SECOND;
        r.busy  = 1'b1;
        r.done  = 1'b0;
        r.op    = op;
        return r;
    endfunction : enter_second

    assign alu.operand  = dst_data;
    assign alu.carry_in = st_q.status_flags_register[bfx_pkg::FLAG_C];
    assign alu.op       = instr_op;

    always_comb begin
        st_d            = st_q;
        st_d.done       = 1'b0;
        st_d.pc_load    = 1'b0;
        st_d.rd_we      = 1'b0;
        st_d.rd_pair_we = 1'b0;
        st_d.io_we      = 1'b0;
        case (st_q.state)
            bfx_pkg::ST_IDLE: begin
                if (instr_valid) begin
                    // single-cycle by default; two-cycle forms override below
                    st_d.done = 1'b1;
                    case (instr_op)
                        bfx_pkg::OP_BRANCH_ON_IRQ_ENABLED: begin
                            if (st_q.status_flags_register[bfx_pkg::FLAG_I]) begin
                                st_d.pc    = branch_target(pc_in, instr_k);
                                st_d       = enter_second(st_d, instr_op);
                            end
                        end
                        bfx_pkg::OP_BRANCH_ON_IRQ_DISABLED: begin
                            if (!st_q.status_flags_register[bfx_pkg::FLAG_I]) begin
                                st_d.pc    = branch_target(pc_in, instr_k);
                                st_d       = enter_second(st_d, instr_op);
                            end
                        end
                        bfx_pkg::OP_IO_BIT_SET,
                        bfx_pkg::OP_IO_BIT_CLEAR: begin
                            // read-modify-write: one cycle to latch, one to write back
                            st_d.io_addr = io_addr_in;
                            st_d.io_data = set_bit(io_rd_data, instr_bit,
                                (instr_op == bfx_pkg::OP_IO_BIT_SET));
                            st_d         = enter_second(st_d, instr_op);
                        end
                        bfx_pkg::OP_SHIFT_LEFT_LOGICAL,
                        bfx_pkg::OP_SHIFT_RIGHT_LOGICAL,
                        bfx_pkg::OP_ROTATE_LEFT_CARRY,
                        bfx_pkg::OP_ROTATE_RIGHT_CARRY,
                        bfx_pkg::OP_ARITH_SHIFT_RIGHT: begin
                            st_d.rd_we   = 1'b1;
                            st_d.rd_data = alu.result;
                            st_d.status_flags_register[bfx_pkg::FLAG_C] = alu.flags[0];
                            st_d.status_flags_register[bfx_pkg::FLAG_Z] = alu.flags[1];
                            st_d.status_flags_register[bfx_pkg::FLAG_N] = alu.flags[2];
                            st_d.status_flags_register[bfx_pkg::FLAG_V] = alu.flags[3];
                        end
                        bfx_pkg::OP_NIBBLE_SWAP: begin
                            st_d.rd_we   = 1'b1;
                            st_d.rd_data = {dst_data[3:0], dst_data[7:4]};
                        end
                        bfx_pkg::OP_GENERIC_FLAG_SET,
                        bfx_pkg::OP_GENERIC_FLAG_CLEAR: begin
                            // dedicated set/clear forms decode to this with a fixed selector
                            st_d.status_flags_register = set_bit(st_q.status_flags_register, flag_op_sel,
                                (instr_op == bfx_pkg::OP_GENERIC_FLAG_SET));
                        end
                        bfx_pkg::OP_REG_BIT_TO_TRANSFER: begin
                            st_d.status_flags_register[bfx_pkg::FLAG_T] = src_data[instr_bit];
                        end
                        bfx_pkg::OP_TRANSFER_TO_REG_BIT: begin
                            st_d.rd_we   = 1'b1;
                            st_d.rd_data = set_bit(dst_data, instr_bit,
                                                   st_q.status_flags_register[bfx_pkg::FLAG_T]);
                        end
                        bfx_pkg::OP_REGISTER_COPY: begin
                            st_d.rd_we   = 1'b1;
                            st_d.rd_data = src_data;
                        end
                        bfx_pkg::OP_REGISTER_PAIR_COPY: begin
                            st_d.rd_pair_we = 1'b1;
                            st_d.rd_data    = src_data;
                            st_d.rd_data_hi = src_data_hi;
                        end
                        bfx_pkg::OP_IMMEDIATE_LOAD: begin
                            st_d.rd_we   = 1'b1;
                            st_d.rd_data = instr_imm;
                        end
                        default: begin
                            st_d.done = 1'b1;
                        end
                    endcase
                end
            end
            bfx_pkg::ST_SECOND: begin
                // second cycle of taken branch or io bit write; requests here are refused
                st_d.state = bfx_pkg::ST_IDLE;
                st_d.busy  = 1'b0;
                st_d.done  = 1'b1;
                if (is_branch_op(st_q.op)) begin
                    st_d.pc_load = 1'b1;
                end else begin
                    st_d.io_we   = 1'b1;
                end
            end
            default: begin
                st_d.state = bfx_pkg::ST_IDLE;
                st_d.busy  = 1'b0;
            end
        endcase
        // flag_op_set unused beyond selection; kept for decoders that encode polarity apart
        if (flag_op_set && instr_valid && st_q.state == bfx_pkg::ST_IDLE &&
            instr_op == bfx_pkg::OP_NOP) begin
            st_d.done = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign busy         = st_q.busy;
    assign done         = st_q.done;
    assign pc_load      = st_q.pc_load;
    assign pc_out       = st_q.pc;
    assign rd_we        = st_q.rd_we;
    assign rd_pair_we   = st_q.rd_pair_we;
    assign rd_data      = st_q.rd_data;
    assign rd_data_hi   = st_q.rd_data_hi;
    assign io_we        = st_q.io_we;
    assign io_addr      = st_q.io_addr;
    assign io_wr_data   = st_q.io_data;
    assign status_flags = st_q.status_flags_register;
endmodule : bfx_exec

// file: bfx_exec_props.sv
// checker: timing and flag relations at the ports of the bit and flag executor
module bfx_exec_props #(
    parameter int PC_W = 16,
    parameter int K_W  = 7
) (
    // clock and reset
    input wire logic                sys_clk,
    input wire logic                resetn,
    // issue
    input wire logic                instr_valid,
    input wire bfx_pkg::bfx_op_type instr_op,
    input wire logic [2:0]          flag_op_sel,
    // results
    input wire logic                busy,
    input wire logic                done,
    input wire logic                pc_load,
    input wire logic                io_we,
    input wire logic                rd_we,
    input wire logic [7:0]          rd_data,
    input wire logic [7:0]          status_flags
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // an issue only counts while idle; a request during busy is dropped
    wire logic take;
    wire logic irq_on;
    assign take   = instr_valid && !busy;
    assign irq_on = status_flags[bfx_pkg::FLAG_I];

    sequence s_two_step;
        busy && !done ##1 done && !busy;
    endsequence

    a_io_two_cycles: assert property (take && instr_op inside {bfx_pkg::OP_IO_BIT_SET,
        bfx_pkg::OP_IO_BIT_CLEAR} |=> s_two_step ##0 io_we && $stable(status_flags))
        else $error("io bit op not done in two cycles");
    a_branch_on_irq_enabled_taken: assert property (take && instr_op == bfx_pkg::OP_BRANCH_ON_IRQ_ENABLED
        && irq_on |=> s_two_step ##0 pc_load)
        else $error("taken branch not two cycles");
    a_branch_on_irq_enabled_fall: assert property (take && instr_op == bfx_pkg::OP_BRANCH_ON_IRQ_ENABLED
        && !irq_on |=> done && !pc_load && !busy)
        else $error("untaken branch not one cycle");
    a_branch_on_irq_disabled_fall: assert property (take && instr_op == bfx_pkg::OP_BRANCH_ON_IRQ_DISABLED
        && irq_on |=> done && !pc_load && !busy && $stable(status_flags))
        else $error("untaken branch on disabled not one cycle");
    a_busy_refused: assert property (instr_valid && busy
        |=> done && !busy && !rd_we && $stable(status_flags))
        else $error("request taken while busy");
    a_branch_on_irq_disabled_taken: assert property (take && instr_op == bfx_pkg::OP_BRANCH_ON_IRQ_DISABLED
        && !irq_on |=> s_two_step ##0 pc_load && status_flags == $past(status_flags, 2))
        else $error("branch on disabled wrong");
    a_shift_flags: assert property (take && instr_op inside
        {[bfx_pkg::OP_SHIFT_LEFT_LOGICAL:bfx_pkg::OP_ARITH_SHIFT_RIGHT]} |=> done && rd_we
        && status_flags[bfx_pkg::FLAG_Z] == (rd_data == 8'h00)
        && status_flags[bfx_pkg::FLAG_N] == rd_data[7]
        && status_flags[bfx_pkg::FLAG_V] == (rd_data[7] ^ status_flags[bfx_pkg::FLAG_C]))
        else $error("shift flags wrong");
    a_swap_flags_kept: assert property (take && instr_op == bfx_pkg::OP_NIBBLE_SWAP
        |=> done && rd_we && $stable(status_flags))
        else $error("swap changed flags");
    a_flag_set_one: assert property (take && instr_op == bfx_pkg::OP_GENERIC_FLAG_SET
        |=> status_flags == ($past(status_flags) | (8'h01 << $past(flag_op_sel))))
        else $error("flag set touched other bits");
    a_flag_clear_one: assert property (take && instr_op == bfx_pkg::OP_GENERIC_FLAG_CLEAR
        |=> status_flags == ($past(status_flags) & ~(8'h01 << $past(flag_op_sel))))
        else $error("flag clear touched other bits");
    a_move_flags_kept: assert property (take && instr_op inside {bfx_pkg::OP_REGISTER_COPY,
        bfx_pkg::OP_REGISTER_PAIR_COPY, bfx_pkg::OP_IMMEDIATE_LOAD,
        bfx_pkg::OP_TRANSFER_TO_REG_BIT} |=> done && $stable(status_flags))
        else $error("move changed flags");
endmodule : bfx_exec_props

bind bfx_exec bfx_exec_props #(.PC_W(PC_W), .K_W(K_W)) u_bfx_exec_props (
    .sys_clk(sys_clk), .resetn(resetn), .instr_valid(instr_valid), .instr_op(instr_op),
    .flag_op_sel(flag_op_sel), .busy(busy), .done(done), .pc_load(pc_load), .io_we(io_we),
    .rd_we(rd_we), .rd_data(rd_data), .status_flags(status_flags)
);

// file: bfx_exec_tb_top.sv
// testbench: random instruction stream against a behavioural flag and result model
module bfx_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                sys_clk     = 1'b0;
    logic                resetn      = 1'b0;
    logic                instr_valid = 1'b0;
    bfx_pkg::bfx_op_type instr_op    = bfx_pkg::OP_NOP;
    logic [2:0]          instr_bit   = 3'h0;
    logic [2:0]          flag_op_sel = 3'h0;
    logic [6:0]          instr_k     = 7'h00;
    logic [7:0]          instr_imm   = 8'h00;
    logic [7:0]          src_data    = 8'h00;
    logic [7:0]          src_data_hi = 8'h00;
    logic [7:0]          dst_data    = 8'h00;
    logic [7:0]          io_rd_data  = 8'h00;
    logic [5:0]          io_addr_in  = 6'h00;
    logic [15:0]         pc_in       = 16'h0000;
    logic                busy, done, pc_load, rd_we, rd_pair_we, io_we;
    logic [15:0]         pc_out;
    logic [7:0]          rd_data, rd_data_hi, io_wr_data, status_flags;
    logic [5:0]          io_addr;
    logic [15:0]         lfsr        = 16'hD119;
    logic [7:0]          fl          = 8'h00;
    int                  num_errors  = 0;
    int                  checked     = 0;

    always #10 sys_clk = ~sys_clk;

    bfx_exec u_bfx_exec (
        .sys_clk, .resetn, .instr_valid, .instr_op, .instr_bit, .instr_k, .instr_imm,
        .flag_op_set(1'b0), .flag_op_sel, .src_data, .src_data_hi, .dst_data, .io_rd_data,
        .io_addr_in, .pc_in, .busy, .done, .pc_load, .pc_out, .rd_we, .rd_pair_we, .rd_data,
        .rd_data_hi, .io_we, .io_addr, .io_wr_data, .status_flags
    );

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic end_of_test();
        $display("errors %0d of %0d checks", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // one operand byte feeds src_data, dst_data, io_rd_data and instr_imm so the model need not guess the operand path
    task automatic exec(input bfx_pkg::bfx_op_type op, input logic [2:0] sel);
        logic [7:0]  d;
        logic [7:0]  r;
        logic [7:0]  ef;
        logic [15:0] ep;
        logic [5:0]  a;
        logic        c;
        int          cyc;
        int          kind;
        int          n;
        d = rnd();
        a = lfsr[13:8];
        c = fl[bfx_pkg::FLAG_C];
        r = d;
        ef = fl;
        ep = {d, ~d} + {{9{d[6]}}, d[6:0]} + 16'h0001;
        cyc = 1;
        kind = 1;
        case (op)
            bfx_pkg::OP_SHIFT_LEFT_LOGICAL: {c, r} = {d, 1'b0};
            bfx_pkg::OP_SHIFT_RIGHT_LOGICAL: {r, c} = {1'b0, d};
            bfx_pkg::OP_ROTATE_LEFT_CARRY: {c, r} = {d, c};
            bfx_pkg::OP_ROTATE_RIGHT_CARRY: {r, c} = {c, d};
            bfx_pkg::OP_ARITH_SHIFT_RIGHT: {r, c} = {d[7], d};
            bfx_pkg::OP_NIBBLE_SWAP: r = {d[3:0], d[7:4]};
            bfx_pkg::OP_TRANSFER_TO_REG_BIT: r[a[2:0]] = fl[bfx_pkg::FLAG_T];
            bfx_pkg::OP_REGISTER_PAIR_COPY: kind = 2;
            bfx_pkg::OP_IO_BIT_SET, bfx_pkg::OP_IO_BIT_CLEAR: begin
                r[a[2:0]] = (op == bfx_pkg::OP_IO_BIT_SET);
                cyc = 2;
                kind = 3;
            end
            bfx_pkg::OP_BRANCH_ON_IRQ_ENABLED, bfx_pkg::OP_BRANCH_ON_IRQ_DISABLED: begin
                cyc = ((op == bfx_pkg::OP_BRANCH_ON_IRQ_ENABLED) == fl[bfx_pkg::FLAG_I]) ? 2 : 1;
                kind = 4;
            end
            bfx_pkg::OP_REG_BIT_TO_TRANSFER: begin
                ef[bfx_pkg::FLAG_T] = d[a[2:0]];
                kind = 0;
            end
            bfx_pkg::OP_GENERIC_FLAG_SET, bfx_pkg::OP_GENERIC_FLAG_CLEAR: begin
                ef[sel] = (op == bfx_pkg::OP_GENERIC_FLAG_SET);
                kind = 0;
            end
            default: ;
        endcase
        if (op inside {[bfx_pkg::OP_SHIFT_LEFT_LOGICAL:bfx_pkg::OP_ARITH_SHIFT_RIGHT]}) begin
            ef[bfx_pkg::FLAG_C] = c;
            ef[bfx_pkg::FLAG_Z] = (r == 8'h00);
            ef[bfx_pkg::FLAG_N] = r[7];
            ef[bfx_pkg::FLAG_V] = r[7] ^ c;
        end
        @(posedge sys_clk);
        instr_op <= op;
        instr_valid <= 1'b1;
        flag_op_sel <= sel;
        instr_bit <= a[2:0];
        io_addr_in <= a;
        instr_k <= d[6:0];
        {src_data, dst_data, io_rd_data, instr_imm} <= {4{d}};
        src_data_hi <= ~d;
        pc_in <= {d, ~d};
        @(posedge sys_clk);
        // a two-cycle op is offered a flag flip while busy: it must be refused
        instr_valid <= (cyc == 2);
        instr_op    <= (cyc == 2) ? (fl[sel] ? bfx_pkg::OP_GENERIC_FLAG_CLEAR
                                             : bfx_pkg::OP_GENERIC_FLAG_SET) : op;
        n = 1;
        #1;
        while (done !== 1'b1 && n < 5) begin
            @(posedge sys_clk);
            instr_valid <= 1'b0;
            #1;
            n++;
        end
        chk(n == cyc, "cycles to done");
        chk(status_flags === ef, "status flags");
        chk(kind != 1 || (rd_we === 1'b1 && rd_data === r), "register result");
        chk(kind != 2 || (rd_pair_we === 1'b1 && rd_data === d && rd_data_hi === ~d),
            "pair copy");
        chk(kind != 3 || (io_we === 1'b1 && io_addr === a && io_wr_data === r), "io write");
        chk(kind != 4 || (pc_load === (cyc == 2) && (cyc == 1 || pc_out === ep)),
            "branch target");
        fl = ef;
        if (done !== 1'b1) begin
            end_of_test();
        end
    endtask : exec

    initial begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        #1;
        chk(status_flags === bfx_pkg::STATUS_RESET && done === 1'b0, "reset state");
        for (int s = 0; s < 8; s++) begin
            exec(bfx_pkg::OP_GENERIC_FLAG_SET, 3'(s));
            exec(bfx_pkg::OP_GENERIC_FLAG_CLEAR, 3'(s));
        end
        for (int i = 0; i < 400; i++) begin
            if (i == 200) begin
                @(posedge sys_clk);
                resetn <= 1'b0;
                @(posedge sys_clk);
                resetn <= 1'b1;
                fl = bfx_pkg::STATUS_RESET;
                #1;
                chk(status_flags === bfx_pkg::STATUS_RESET && busy === 1'b0
                    && done === 1'b0, "state after mid-run reset");
            end
            exec(bfx_pkg::bfx_op_type'(5'h01 + 5'(rnd() % 8'h11)), lfsr[2:0]);
        end
        end_of_test();
    end
endmodule : bfx_exec_tb_top
